/* File: hw/mcr_array.sv */
// macrocell register array with global clocking, clears and programming port
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module mcr_array #(
    parameter int             N               = 16,
    parameter bit             ENHANCED        = 1'b1,
    parameter logic [15:0]    POWERUP_INIT    = 16'h0000,
    parameter logic           DONE_AT_POWERUP = 1'b1,
    parameter int unsigned    TRANS_CYCLES    = mcr_pkg::ISP_TRANS_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [mcr_pkg::AW-1:0] reg_addr,
    input  wire logic [mcr_pkg::DW-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [mcr_pkg::DW-1:0]     reg_rdata,
    input  wire logic                  global_clock_pin_one,
    input  wire logic                  global_clock_pin_two,
    input  wire logic                  global_clear_pin_low,
    input  wire logic                  global_oe_pin_one,
    input  wire logic                  global_oe_pin_two,
    output logic [3:0]                 dedicated_in,
    input  wire logic [N-1:0]          pt_data,
    input  wire logic [N-1:0]          pt_aux,
    input  wire logic [N-1:0]          pt_enable,
    input  wire logic [N-1:0]          pt_clock,
    input  wire logic [N-1:0]          pt_preset,
    input  wire logic [N-1:0]          pt_clear,
    input  wire logic [N-1:0]          io_in,
    output logic [N-1:0]               io_out,
    output logic [N-1:0]               io_oe,
    output logic                       io_pullup,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdo_oe
);
    import mcr_pkg::*;

    function automatic logic net_level(logic pin_two, logic inv, logic p1, logic p2);
        return (pin_two ? p2 : p1) ^ inv;
    endfunction

    function automatic logic cell_hit(logic [AW-1:0] a, int idx);
        return a == (REG_CELL_BASE + AW'(idx));
    endfunction

    function automatic mcr_tap_t tap_next(mcr_tap_t s, logic m);
        unique case (s)
            TAP_RESET:  return m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   return m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  return m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  return m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: return m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  return m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  return m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    // register file
    logic [DW-1:0] glob_q;
    logic [DW-1:0] cfg_q [N];
    logic [DW-1:0] rd_d;
    logic [DW-1:0] reg_rdata_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            glob_q <= GLOBAL_RESET;
            for (int i = 0; i < N; i++) begin
                cfg_q[i] <= CFG_RESET;
            end
        end else if (reg_wr) begin
            if (reg_addr == REG_GLOBAL) begin
                glob_q <= reg_wdata;
            end
            for (int i = 0; i < N; i++) begin
                if (cell_hit(reg_addr, i)) begin
                    cfg_q[i] <= reg_wdata;
                end
            end
        end
    end

    // global clock nets: edges seen on the system clock
    logic [1:0] gnet;
    logic [1:0] gnet_q;
    logic [1:0] gedge;
    logic [N-1:0] ptclk_q;
    logic [N-1:0] aedge;

    assign gnet[0] = net_level(glob_q[G_NET0_PIN], glob_q[G_NET0_INV],
                               global_clock_pin_one, global_clock_pin_two);    // [RQ5]
    assign gnet[1] = net_level(glob_q[G_NET1_PIN], glob_q[G_NET1_INV],
                               global_clock_pin_one, global_clock_pin_two);    // [RQ5]
    assign gedge   = gnet & ~gnet_q;
    assign aedge   = pt_clock & ~ptclk_q;

    // a net already high at reset release gives no edge: the history resets high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gnet_q  <= '1;
            ptclk_q <= '1;
        end else begin
            gnet_q  <= gnet;
            ptclk_q <= pt_clock;
        end
    end

    // per-cell control decode
    logic [N-1:0] tick;
    logic [N-1:0] d_in;
    logic [N-1:0] clr;
    logic [N-1:0] cell_q;
    logic [N-1:0] cell_comb;
    logic [N-1:0] oe_want;

    for (genvar i = 0; i < N; i++) begin : g_cell
        mcr_cm_t cm;
        mcr_oe_t oe;
        logic    net;
        assign cm  = mcr_cm_t'(cfg_q[i][F_CM_MSB:F_CM_LSB]);
        assign oe  = mcr_oe_t'(cfg_q[i][F_OE_MSB:F_OE_LSB]);
        assign net = cfg_q[i][F_NET];
        // an unused mode code gives no clock at all
        assign tick[i] = (cm == CM_GLOBAL) ? gedge[net] :
                         (cm == CM_GATED)  ? (gedge[net] & pt_enable[i]) :   // [RQ3] [RQ15]
                         (cm == CM_ARRAY)  ? aedge[i] : 1'b0;                // [RQ4]
        assign d_in[i] = cfg_q[i][F_FAST] ? io_in[i] : pt_data[i];          // [RQ9]
        assign clr[i]  = pt_clear[i] | (cfg_q[i][F_GCLR] & ~global_clear_pin_low); // [RQ7]
        assign oe_want[i] = (oe == OE_ALWAYS)
                          | ((oe == OE_GLOBAL_ONE) & global_oe_pin_one)     // [RQ10]
                          | ((oe == OE_GLOBAL_TWO) & global_oe_pin_two);    // [RQ10]

        mcr_cell #(
            .INIT (ENHANCED ? POWERUP_INIT[i] : 1'b0)                       // [RQ8]
        ) u_cell (
            .clk      (clk),
            .nrst     (nrst),
            .ff_type  (mcr_ff_t'(cfg_q[i][F_FF_MSB:F_FF_LSB])),
            .bypass   (cfg_q[i][F_BYPASS]),
            .tick     (tick[i]),
            .in_a     (d_in[i]),
            .in_b     (pt_aux[i]),
            .preset   (pt_preset[i]),
            .clear    (clr[i]),
            .q        (cell_q[i]),
            .comb_out (cell_comb[i])
        );
    end

    // boundary-scan port, sampled on the system clock
    mcr_tap_t tap_q;
    logic     tck_q;
    logic     tck_rise;
    logic     tck_fall;
    logic [IR_LEN-1:0] ir_sh_q;
    logic [IR_LEN-1:0] ir_q;
    logic     byp_q;
    logic     act_q;
    logic     tdo_q;
    logic     tdo_oe_q;

    assign tck_rise = tck & ~tck_q;
    assign tck_fall = ~tck & tck_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_q <= 1'b0;
            tap_q <= TAP_RESET;
        end else begin
            tck_q <= tck;
            if (tck_rise) begin
                tap_q <= tap_next(tap_q, tms);                              // [RQ11]
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= IR_BYPASS;
            byp_q   <= 1'b0;
            act_q   <= 1'b0;
        end else begin
            act_q <= 1'b0;
            if (tck_rise) begin
                unique case (tap_q)
                    TAP_RESET:  ir_q    <= IR_BYPASS;
                    TAP_CAP_IR: ir_sh_q <= IR_CAPTURE;
                    TAP_SH_IR:  ir_sh_q <= {tdi, ir_sh_q[IR_LEN-1:1]};
                    TAP_CAP_DR: byp_q   <= 1'b0;
                    TAP_SH_DR:  byp_q   <= tdi;
                    TAP_UPD_IR: begin
                        ir_q  <= ir_sh_q;
                        act_q <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // data leaves on the falling test clock, as the scan chain expects
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= (tap_q == TAP_SH_IR) ? ir_sh_q[0] : byp_q;
            tdo_oe_q <= (tap_q == TAP_SH_IR) | (tap_q == TAP_SH_DR);        // [RQ11]
        end
    end

    // programming mode sequencer and completion bit
    mcr_isp_t isp_q;
    logic [$clog2(TRANS_CYCLES+1)-1:0] trans_q;
    logic     done_q;
    logic     trans_end;

    assign trans_end = trans_q == ($bits(trans_q))'(TRANS_CYCLES - 1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            isp_q   <= ISP_USER;
            trans_q <= '0;
        end else begin
            unique case (isp_q)
                ISP_USER: begin
                    trans_q <= '0;
                    if (act_q && ir_q == IR_ISP_ENTER) begin
                        isp_q <= ISP_ENTERING;                              // [RQ11]
                    end
                end
                ISP_ENTERING, ISP_EXITING: begin
                    trans_q <= trans_q + 1'b1;
                    if (trans_end) begin
                        trans_q <= '0;
                        isp_q   <= (isp_q == ISP_ENTERING) ? ISP_ACTIVE : ISP_USER;
                    end
                end
                ISP_ACTIVE: begin
                    if (act_q && ir_q == IR_ISP_EXIT) begin
                        isp_q <= ISP_EXITING;
                    end
                end
            endcase
        end
    end

    // the completion bit reloads DONE_AT_POWERUP on reset; erase clears it so a broken run stays dark until then
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_q <= DONE_AT_POWERUP;
        end else if (act_q && isp_q == ISP_ACTIVE) begin
            if (ir_q == IR_ERASE) begin
                done_q <= 1'b0;                                             // [RQ13]
            end else if (ir_q == IR_DONE_SET) begin
                done_q <= 1'b1;                                             // [RQ13]
            end
        end
    end

    // io pins and dedicated inputs, all registered
    logic [N-1:0] io_out_q;
    logic [N-1:0] io_oe_q;
    logic         io_pullup_q;
    logic [3:0]   ded_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            io_out_q    <= '0;
            io_oe_q     <= '0;
            io_pullup_q <= 1'b0;
            ded_q       <= '0;
        end else begin
            io_out_q    <= cell_comb;
            io_oe_q     <= (isp_q == ISP_USER && done_q) ? oe_want : '0;    // [RQ12] [RQ13]
            io_pullup_q <= isp_q != ISP_USER;                               // [RQ12]
            ded_q       <= {global_oe_pin_two, global_oe_pin_one,
                            global_clear_pin_low, global_clock_pin_one};    // [RQ10]
        end
    end

    always_comb begin
        rd_d = '0;
        if (reg_addr == REG_GLOBAL) begin
            rd_d = glob_q;
        end else if (reg_addr == REG_STATUS) begin
            rd_d[S_DONE]              = done_q;
            rd_d[S_ISP_MSB:S_ISP_LSB] = isp_q;
            rd_d[S_DED_MSB:S_DED_LSB] = ded_q;
        end else if (reg_addr == REG_OUTPUTS) begin
            rd_d[N-1:0] = cell_q;
        end
        for (int i = 0; i < N; i++) begin
            if (cell_hit(reg_addr, i)) begin
                rd_d = cfg_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_d : '0;
        end
    end

    assign reg_rdata    = reg_rdata_q;
    assign io_out       = io_out_q;
    assign io_oe        = io_oe_q;
    assign io_pullup    = io_pullup_q;
    assign dedicated_in = ded_q;
    assign tdo          = tdo_q;
    assign tdo_oe       = tdo_oe_q;

    // checks on cell 0, plus io enable and pull-up checks on every pin
    logic    quiet0;
    mcr_cm_t cm0;
    mcr_ff_t ff0;
    assign quiet0 = ~pt_preset[0] & ~clr[0];
    assign cm0    = mcr_cm_t'(cfg_q[0][F_CM_MSB:F_CM_LSB]);
    assign ff0    = mcr_ff_t'(cfg_q[0][F_FF_MSB:F_FF_LSB]);

    chk_gated_hold: assert property (@(posedge clk) disable iff (!nrst)  // [RQ15]
        cm0 == CM_GATED && !pt_enable[0] && quiet0 |=> $stable(cell_q[0]))
        else $error("gated cell changed with enable low");
    chk_gated_update: assert property (@(posedge clk) disable iff (!nrst) // [RQ3]
        cm0 == CM_GATED && ff0 == FF_D && gedge[cfg_q[0][F_NET]] && pt_enable[0] && quiet0
        |=> cell_q[0] == $past(d_in[0]))
        else $error("gated cell missed its update");
    chk_array_clock: assert property (@(posedge clk) disable iff (!nrst)  // [RQ4]
        cm0 == CM_ARRAY && ff0 == FF_D && aedge[0] && quiet0 |=> cell_q[0] == $past(d_in[0]))
        else $error("array clock did not load cell");
    chk_toggle_type: assert property (@(posedge clk) disable iff (!nrst)  // [RQ1]
        ff0 == FF_T && tick[0] && d_in[0] && quiet0 |=> cell_q[0] != $past(cell_q[0]))
        else $error("toggle cell did not toggle");
    chk_preset_sets: assert property (@(posedge clk) disable iff (!nrst)  // [RQ6]
        pt_preset[0] && !clr[0] |=> cell_q[0])
        else $error("preset did not set cell");
    chk_global_clear: assert property (@(posedge clk) disable iff (!nrst) // [RQ7]
        cfg_q[0][F_GCLR] && !global_clear_pin_low |=> !cell_q[0])
        else $error("global clear did not clear cell");
    chk_bypass_path: assert property (@(posedge clk) disable iff (!nrst)  // [RQ2]
        cfg_q[0][F_BYPASS] |=> io_out[0] == $past(d_in[0]))
        else $error("bypassed cell not combinatorial");
    chk_done_inhibit: assert property (@(posedge clk) disable iff (!nrst) // [RQ13]
        !done_q |=> io_oe == '0)
        else $error("io driven before completion bit");
    chk_isp_float: assert property (@(posedge clk) disable iff (!nrst)    // [RQ12]
        isp_q != ISP_USER |=> io_oe == '0 && io_pullup)
        else $error("io not floating during programming");

    cov_isp_enter: cover property (@(posedge clk) disable iff (!nrst)
        isp_q == ISP_ENTERING ##1 isp_q == ISP_ACTIVE);
    cov_done_set: cover property (@(posedge clk) disable iff (!nrst) $rose(done_q));
    cov_gated_hold: cover property (@(posedge clk) disable iff (!nrst)
        cm0 == CM_GATED && gedge[0] && !pt_enable[0]);
    cov_array_tick: cover property (@(posedge clk) disable iff (!nrst)
        cm0 == CM_ARRAY && aedge[0]);
endmodule // mcr_array

/* File: hw/mcr_pkg.sv */
// package: field layout, encodings and timing for the macrocell register array
// Function
// RQ1: each cell independently behaves as a D, T, JK or SR flip-flop
// RQ2: a cell may be bypassed so its output is purely combinatorial
// RQ3: gated mode clocks on a global clock only while the enable term is high
// RQ4: array mode clocks the register from a product term
// RQ5: two global clock nets, each true or inverted of either clock pin
// RQ6: product-term preset and clear act at once, active high
// RQ7: the active-low global clear pin may drive any chosen cell's clear
// RQ8: cells take a configured power-up value; older variants start low
// RQ9: each io pin has a direct path to its cell's register input
// RQ10: four dedicated pins serve as plain inputs or global controls
// RQ11: programming is accepted over a four-pin boundary-scan port
// RQ12: during programming all io pins float with a weak pull-up
// RQ13: completion bit is programmed last; until then no io pin drives
// RQ14: older parts need an adaptive programmer; newer accept a fixed one
// RQ15: gated mode holds the value on edges where the enable is low
package mcr_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned ISP_TRANS_US  = 1000;
    localparam int unsigned ISP_TRANS_CYC = ISP_TRANS_US * (CLK_HZ / 1_000_000);
    localparam int AW = 8;
    localparam int DW = 16;
    localparam logic [AW-1:0] REG_GLOBAL    = 8'h00;
    localparam logic [AW-1:0] REG_STATUS    = 8'h01;
    localparam logic [AW-1:0] REG_OUTPUTS   = 8'h02;
    localparam logic [AW-1:0] REG_CELL_BASE = 8'h10;
    // per-cell configuration word
    localparam int F_FF_LSB = 0;
    localparam int F_FF_MSB = 1;
    localparam int F_BYPASS = 2;
    localparam int F_CM_LSB = 3;
    localparam int F_CM_MSB = 4;
    localparam int F_NET    = 5;
    localparam int F_GCLR   = 6;
    localparam int F_FAST   = 7;
    localparam int F_OE_LSB = 8;
    localparam int F_OE_MSB = 9;
    localparam logic [DW-1:0] CFG_RESET    = 16'h0100;
    // global word: net pin selects and inversions
    localparam int G_NET0_PIN = 0;
    localparam int G_NET0_INV = 1;
    localparam int G_NET1_PIN = 2;
    localparam int G_NET1_INV = 3;
    localparam logic [DW-1:0] GLOBAL_RESET = 16'h0004;
    localparam int S_DONE    = 0;
    localparam int S_ISP_LSB = 1;
    localparam int S_ISP_MSB = 2;
    localparam int S_DED_LSB = 4;
    localparam int S_DED_MSB = 7;
    // boundary-scan instruction register
    localparam int IR_LEN = 10;
    localparam logic [IR_LEN-1:0] IR_CAPTURE   = 10'h001;
    localparam logic [IR_LEN-1:0] IR_BYPASS    = 10'h3ff;
    localparam logic [IR_LEN-1:0] IR_ISP_ENTER = 10'h2c0;
    localparam logic [IR_LEN-1:0] IR_ISP_EXIT  = 10'h2c1;
    localparam logic [IR_LEN-1:0] IR_DONE_SET  = 10'h2c2;
    localparam logic [IR_LEN-1:0] IR_ERASE     = 10'h2c3;
    typedef enum logic [1:0] {FF_D = 2'h0, FF_T = 2'h1, FF_JK = 2'h2, FF_SR = 2'h3} mcr_ff_t;
    typedef enum logic [1:0] {CM_GLOBAL = 2'h0, CM_GATED = 2'h1, CM_ARRAY = 2'h2} mcr_cm_t;
    typedef enum logic [1:0] {OE_ALWAYS = 2'h0, OE_NEVER = 2'h1,
                              OE_GLOBAL_ONE = 2'h2, OE_GLOBAL_TWO = 2'h3} mcr_oe_t;
    typedef enum logic [1:0] {ISP_USER = 2'h0, ISP_ENTERING = 2'h1,
                              ISP_ACTIVE = 2'h3, ISP_EXITING = 2'h2} mcr_isp_t;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
        TAP_EX2_IR, TAP_UPD_IR
    } mcr_tap_t;
endpackage

/* File: hw/mcr_cell.sv */
// one macrocell storage element with flip-flop emulation and bypass
`timescale 1ns/1ps
module mcr_cell #(
    parameter logic INIT = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    input  mcr_pkg::mcr_ff_t     ff_type,
    input  wire logic            bypass,
    input  wire logic            tick,
    input  wire logic            in_a,
    input  wire logic            in_b,
    input  wire logic            preset,
    input  wire logic            clear,
    output logic                 q,
    output logic                 comb_out
);
    import mcr_pkg::*;

    logic q_q;
    logic q_d;

    always_comb begin
        q_d = q_q;
        if (tick) begin
            unique case (ff_type)
                FF_D:  q_d = in_a;                                          // [RQ1]
                FF_T:  q_d = q_q ^ in_a;                                    // [RQ1]
                FF_JK: q_d = (in_a & ~q_q) | (~in_b & q_q);                 // [RQ1]
                FF_SR: q_d = in_a & ~in_b ? 1'b1 : (in_b & ~in_a ? 1'b0 : q_q); // [RQ1]
            endcase
        end
        // preset and clear override any clock; clear wins if both are high
        if (preset) begin
            q_d = 1'b1;                                                     // [RQ6]
        end
        if (clear) begin
            q_d = 1'b0;                                                     // [RQ6]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_q <= INIT;                                                    // [RQ8]
        end else begin
            q_q <= q_d;
        end
    end

    assign q        = q_q;
    assign comb_out = bypass ? in_a : q_q;                                  // [RQ2]
endmodule // mcr_cell

/* File: test/mcr_prog.sv */
// programmer model: shifts one instruction into the scan port per request
`timescale 1ns/1ps
module mcr_prog #(
    parameter int HALF = 2
) (
    input  wire logic       clk,
    input  wire logic [9:0] code,
    input  wire logic       go,
    output logic            tck,
    output logic            tms,
    output logic            tdi,
    output logic            busy
);
    // tms per step: idle, to shift-ir, ten bits, exit, update, idle
    localparam logic [16:0] TMS_SEQ = 17'h0c006;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        busy = 1'b0;
    end
    // fixed step list, no read-back adaption
    always begin
        @(posedge clk);
        if (go) begin
            busy <= 1'b1;
            for (int i = 0; i < 17; i++) begin
                tms <= TMS_SEQ[i];
                // outside the shift the data line toggles so no stale bit lingers
                tdi <= (i > 4 && i < 15) ? code[i-5] : ~tdi;
                repeat (HALF) @(posedge clk);
                tck <= 1'b1;
                repeat (HALF) @(posedge clk);
                tck <= 1'b0;
            end
            busy <= 1'b0;
        end
    end
endmodule // mcr_prog

/* File: test/cpld_macrocell_register_bench.sv */
// self-checking bench for the macrocell register array
`timescale 1ns/1ps
module cpld_macrocell_register_bench;
    import mcr_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic        ck1 = 1'b0, ck2 = 1'b0, clr_n = 1'b1, oe1 = 1'b0, oe2 = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [9:0]  code = 10'h000;
    logic [15:0] wdata = 16'h0000, rdata, rv;
    logic [3:0]  pd = 4'h0, pa = 4'h0, pe = 4'h0, pc = 4'h0, pp = 4'h0, pr = 4'h0;
    logic [3:0]  fin = 4'h0, ded, io_out, io_oe;
    logic        pull, tck, tms, tdi, busy, tdo, tdo_oe;
    logic        scan_seen = 1'b0, scan_first = 1'b0;
    int          error_cnt = 0, compares = 0;
    // {cfg low byte, data, aux, enable, source, -, -, -, expected io_out}
    logic [15:0] rows [22] = '{16'h0081, 16'h0000, 16'h0181, 16'h0101, 16'h0180,
        16'h0281, 16'h02c0, 16'h02c1, 16'h0240, 16'h0381, 16'h03c1, 16'h0340,
        16'h0880, 16'h08a1, 16'h1001, 16'h1010, 16'h1091, 16'h0011, 16'h2010,
        16'h8001, 16'h0481, 16'h0410};
    mcr_array #(.N(4), .POWERUP_INIT(16'h0002), .TRANS_CYCLES(8)) dut_u (
        .clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .global_clock_pin_one(ck1),
        .global_clock_pin_two(ck2), .global_clear_pin_low(clr_n),
        .global_oe_pin_one(oe1), .global_oe_pin_two(oe2), .dedicated_in(ded),
        .pt_data(pd), .pt_aux(pa), .pt_enable(pe), .pt_clock(pc), .pt_preset(pp),
        .pt_clear(pr), .io_in(fin), .io_out(io_out), .io_oe(io_oe),
        .io_pullup(pull), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    mcr_prog prog_u (.clk(clk), .code(code), .go(go), .tck(tck), .tms(tms),
        .tdi(tdi), .busy(busy));
    always #20 clk = ~clk;
    // first bit out of an instruction shift is the low bit of the capture value
    always @(posedge clk) begin
        if (tdo_oe && !scan_seen) begin
            scan_first <= tdo;
        end
        scan_seen <= scan_seen | tdo_oe;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        wt(1);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so take them at that edge
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        wt(1);
        rd <= 1'b0;
        wt(1);
        d = rdata;
    endtask
    // source 0 pulses clock pin one, source 1 pin two and the array clock
    task automatic tick(input logic src);
        ck1 <= ~src;
        ck2 <= src;
        pc[0] <= src;
        wt(3);
        ck1 <= 1'b0;
        ck2 <= 1'b0;
        pc[0] <= 1'b0;
        wt(4);
    endtask
    task automatic prog(input logic [9:0] c);
        code <= c;
        go <= 1'b1;
        wt(1);
        go <= 1'b0;
        wt(2);
        for (int i = 0; i < 200 && busy; i++) wt(1);
        if (busy !== 1'b0) begin
            check("programmer busy", 16'h0000, {15'h0, busy});
            complete_run();
        end else begin
            wt(20);
        end
    endtask
    initial begin
        wt(10);
        nrst <= 1'b1;
        wt(2);
        rreg(REG_OUTPUTS, rv);
        check("power-up", 16'h0002, rv);
        rreg(8'h7f, rv);
        check("unmapped", 16'h0000, rv);
        foreach (rows[k]) begin
            wreg(REG_CELL_BASE, {8'h00, rows[k][15:8]});
            pd[0] <= rows[k][7];
            fin[0] <= ~rows[k][7];
            pa[0] <= rows[k][6];
            pe[0] <= rows[k][5];
            tick(rows[k][4]);
            rv = {15'h0, io_out[0]};
            check("io_out", {15'h0, rows[k][0]}, rv);
        end
        wreg(REG_CELL_BASE, 16'h0040);
        pp[0] <= 1'b1;
        wt(4);
        check("preset", 16'h0001, {15'h0, io_out[0]});
        pr[0] <= 1'b1;
        wt(4);
        check("clear", 16'h0000, {15'h0, io_out[0]});
        pr[0] <= 1'b0;
        clr_n <= 1'b0;
        wt(4);
        check("gclr", 16'h0000, {15'h0, io_out[0]});
        wreg(REG_CELL_BASE, 16'h0000);
        wt(4);
        check("gclr off", 16'h0001, {15'h0, io_out[0]});
        pp[0] <= 1'b0;
        clr_n <= 1'b1;
        oe1 <= 1'b1;
        wt(4);
        check("dedicated", 16'h0006, {12'h0, ded});
        pd[0] <= 1'b0;
        tick(1'b0);
        wreg(REG_GLOBAL, 16'h0006);
        pd[0] <= 1'b1;
        ck1 <= 1'b1;
        wt(4);
        check("inverted rise", 16'h0000, {15'h0, io_out[0]});
        ck1 <= 1'b0;
        wt(4);
        check("inverted fall", 16'h0001, {15'h0, io_out[0]});
        rreg(REG_STATUS, rv);
        check("status", 16'h0061, rv);
        check("oe user", 16'h0001, {12'h0, io_oe});
        prog(IR_ISP_ENTER);
        check("scan out", 16'h0003, {13'h0, tdo_oe, scan_seen, scan_first});
        check("pullup", 16'h0001, {15'h0, pull});
        check("oe isp", 16'h0000, {12'h0, io_oe});
        prog(IR_ERASE);
        prog(IR_ISP_EXIT);
        rreg(REG_STATUS, rv);
        check("status erased", 16'h0060, rv);
        check("oe undone", 16'h0000, {12'h0, io_oe});
        prog(IR_ISP_ENTER);
        prog(IR_DONE_SET);
        prog(IR_ISP_EXIT);
        check("oe done", 16'h0001, {12'h0, io_oe});
        complete_run();
    end
endmodule // cpld_macrocell_register_bench
